// file: core/sptout_pkg.sv
// package for the setpoint output block: register map, field layout, reset values, timing
// assumes a 20 MHz apb clock and one setpoint channel per instance
package sptout_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] SPT_CTRL_OFF = 8'h00;
  localparam logic [7:0] SPT_VALUE_OFF = 8'h04;
  localparam logic [7:0] SPT_HYST_OFF = 8'h08;
  localparam logic [7:0] SPT_ONDLY_OFF = 8'h0C;
  localparam logic [7:0] SPT_OFFDLY_OFF = 8'h10;
  localparam logic [7:0] SPT_MEAS_OFF = 8'h14;
  localparam logic [7:0] SPT_CMD_OFF = 8'h18;
  localparam logic [7:0] SPT_STATUS_OFF = 8'h1C;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_ACT_LSB = 0;
  localparam int CTRL_RST_LSB = 2;
  localparam int CTRL_RSTDSP_BIT = 4;
  localparam int CTRL_STBY_BIT = 5;
  localparam int CTRL_COLOR_BIT = 6;
  localparam int CTRL_DP_LSB = 8;
  localparam int CTRL_EN_BIT = 11;

  // command register bits, write one to act
  localparam int CMD_SERIAL_BIT = 0;
  localparam int CMD_UPDATE_BIT = 1;

  // status register bits
  localparam int STAT_OUT_BIT = 0;
  localparam int STAT_PEND_BIT = 1;
  localparam int STAT_STBY_BIT = 2;
  localparam int STAT_COLOR_BIT = 3;
  localparam int STAT_TRIG_BIT = 4;

  // ----------------------------------------------------------------
  // value limits, counts in display units; the delay limit counts tenths of a second
  // ----------------------------------------------------------------
  localparam logic signed [31:0] SPT_MIN = -32'sd19999;
  localparam logic signed [31:0] SPT_MAX = 32'sd99999;
  localparam logic [15:0] HYST_MIN = 16'h0001;
  localparam logic [15:0] HYST_MAX = 16'hEA5F;
  localparam logic [12:0] DLY_MAX = 13'h176F;

  // ----------------------------------------------------------------
  // timing: delays count in tenths of a second
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20000000;
  localparam int TENTH_S_PER_S = 10;
  localparam int TENTH_CYCLES = CLK_HZ / TENTH_S_PER_S;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [11:0] CTRL_RESET = 12'h000;
  localparam logic [31:0] VALUE_RESET = 32'h0000_0000;
  localparam logic [15:0] HYST_RESET = 16'h0001;
  localparam logic [12:0] DLY_RESET = 13'h0000;

  typedef enum logic [1:0] {
    high_acting_balanced,
    low_acting_balanced,
    high_acting_unbalanced,
    low_acting_unbalanced
  } sptout_action_t;

  typedef enum logic [1:0] {
    auto_reset_mode,
    latch_immediate_reset_mode,
    latch_delayed_reset_mode
  } sptout_rstmode_t;

endpackage

// file: core/sptout_core.sv
// setpoint output logic: hysteresis compare, on/off delays, reset modes, standby, colour
// assumes an apb master on pclk and a measurement update strobe from the display path
//
// Contract
// - four actions, high or low acting, balanced or unbalanced hysteresis.
// - signed setpoint accepted from -19999 to 99999, clamped otherwise.
// - setpoint and hysteresis share the display decimal point position.
// - hysteresis accepted from 1 to 59999 counts, clamped otherwise.
// - unbalanced band sits below high-acting, above low-acting setpoints.
// - on-delay 0.0 to 599.9 seconds before asserting the output.
// - separate off-delay 0.0 to 599.9 seconds before deasserting.
// - zero delay makes the output follow the compare at update rate.
// - auto mode turns off at off point; manual reset clears until recrossed.
// - latched output stays on until panel, user, serial reset or power cycle.
// - latch immediate mode clears at once on reset, until trigger recrossed.
// - latch delayed mode holds reset pending until off point is crossed.
// - at power-up a latched output comes up off if display below setpoint; code clears it at first update when display >= setpoint, not at off point.
// - power cycle discards a pending delayed reset not active at power-up.
// - display reset also resets the output when that option is enabled.
// - that reset needs source set to display reset and input displayed.
// - standby holds output off after power-up until trigger first crossed.
// - colour change option toggles backlight colour when output changes.
//
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps

module sptout_core
  import sptout_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic meas_update,
  input wire logic signed [31:0] meas_value,
  input wire logic panel_reset,
  input wire logic user_reset,
  input wire logic panel_rst_is_dsp,
  input wire logic user_rst_is_dsp,
  input wire logic input_displayed,
  output logic setpoint_out,
  output logic backlight_alt
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [11:0] ctrl;
    logic signed [31:0] spt;
    logic [15:0] hyst;
    logic [12:0] on_dly;
    logic [12:0] off_dly;
    logic signed [31:0] meas;
    logic [12:0] dly_cnt;
    logic [21:0] tick_cnt;
    logic out;
    logic pend;
    logic man_clr;
    logic stby;
    logic color;
    logic trig;
    logic first;
    logic [31:0] rdata;
  } sptout_state_t;

  sptout_state_t state_ff;
  sptout_state_t nxt_state;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic signed [31:0] clamp_spt(input logic [31:0] v);
    logic signed [31:0] s;
    s = $signed(v);
    if (s < SPT_MIN) begin
      clamp_spt = SPT_MIN;
    end else if (s > SPT_MAX) begin
      clamp_spt = SPT_MAX;
    end else begin
      clamp_spt = s;
    end
  endfunction

  function automatic logic [12:0] clamp_dly(input logic [31:0] v);
    if (v > {19'h0_0000, DLY_MAX}) begin
      clamp_dly = DLY_MAX;
    end else begin
      clamp_dly = v[12:0];
    end
  endfunction

  logic apb_wr;
  logic apb_rd;
  logic [31:0] wdata;
  logic dsp_reset;
  logic manual_reset;
  logic high_act;
  logic unbal;
  logic signed [31:0] on_pt;
  logic signed [31:0] off_pt;
  logic at_on;
  logic at_off;
  logic want;
  logic [12:0] dly_sel;
  logic tenth;
  logic [1:0] rmode;

  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = state_ff.rdata;
  assign setpoint_out = state_ff.out;
  assign backlight_alt = state_ff.color;
  assign apb_wr = psel & penable & pwrite;
  assign apb_rd = psel & ~penable & ~pwrite;
  assign wdata = pwdata;

  always_comb begin
    nxt_state = state_ff;
    dly_sel = 13'h0000;

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    if (apb_wr) begin
      case (paddr)
        SPT_CTRL_OFF: nxt_state.ctrl = wdata[11:0];
        SPT_VALUE_OFF: nxt_state.spt = clamp_spt(wdata);
        SPT_HYST_OFF: begin
          if (wdata[15:0] < HYST_MIN || wdata[31:16] != 16'h0000 && 1'b0) begin
            nxt_state.hyst = HYST_MIN;
          end else if (wdata[31:16] != 16'h0000 || wdata[15:0] > HYST_MAX) begin
            nxt_state.hyst = HYST_MAX;
          end else begin
            nxt_state.hyst = wdata[15:0];
          end
        end
        SPT_ONDLY_OFF: nxt_state.on_dly = clamp_dly(wdata);
        SPT_OFFDLY_OFF: nxt_state.off_dly = clamp_dly(wdata);
        SPT_MEAS_OFF: nxt_state.meas = $signed(wdata);
        default: begin
        end
      endcase
    end

    // read data registered in setup so it is stable through the access phase
    if (apb_rd) begin
      case (paddr)
        SPT_CTRL_OFF: nxt_state.rdata = {20'h0_0000, state_ff.ctrl};
        SPT_VALUE_OFF: nxt_state.rdata = state_ff.spt;
        SPT_HYST_OFF: nxt_state.rdata = {16'h0000, state_ff.hyst};
        SPT_ONDLY_OFF: nxt_state.rdata = {19'h0_0000, state_ff.on_dly};
        SPT_OFFDLY_OFF: nxt_state.rdata = {19'h0_0000, state_ff.off_dly};
        SPT_MEAS_OFF: nxt_state.rdata = state_ff.meas;
        SPT_STATUS_OFF: nxt_state.rdata = {27'h000_0000, state_ff.trig, state_ff.color,
                                           state_ff.stby, state_ff.pend, state_ff.out};
        default: nxt_state.rdata = 32'h0000_0000;
      endcase
    end

    // ----------------------------------------------------------------
    // trigger points; the decimal point only labels counts, so
    // raw counts compare directly
    // ----------------------------------------------------------------
    high_act = (state_ff.ctrl[CTRL_ACT_LSB +: 2] == high_acting_balanced) ||
               (state_ff.ctrl[CTRL_ACT_LSB +: 2] == high_acting_unbalanced);
    unbal = state_ff.ctrl[CTRL_ACT_LSB + 1];
    if (high_act) begin
      on_pt = unbal ? state_ff.spt : state_ff.spt + $signed({16'h0000, state_ff.hyst});
      off_pt = state_ff.spt - $signed({16'h0000, state_ff.hyst});
      at_on = state_ff.meas >= on_pt;
      at_off = state_ff.meas <= off_pt;
    end else begin
      on_pt = unbal ? state_ff.spt : state_ff.spt - $signed({16'h0000, state_ff.hyst});
      off_pt = state_ff.spt + $signed({16'h0000, state_ff.hyst});
      at_on = state_ff.meas <= on_pt;
      at_off = state_ff.meas >= off_pt;
    end

    // ----------------------------------------------------------------
    // reset sources
    // ----------------------------------------------------------------
    dsp_reset = state_ff.ctrl[CTRL_RSTDSP_BIT] & input_displayed &
                ((panel_reset & panel_rst_is_dsp) | (user_reset & user_rst_is_dsp));
    manual_reset = panel_reset | user_reset | dsp_reset |
                   (apb_wr && paddr == SPT_CMD_OFF && wdata[CMD_SERIAL_BIT]);
    rmode = state_ff.ctrl[CTRL_RST_LSB +: 2];

    // tenth-second time base for the delay counters
    tenth = (state_ff.tick_cnt == 22'(TENTH_CYCLES - 1));
    nxt_state.tick_cnt = tenth ? 22'h00_0000 : state_ff.tick_cnt + 22'h00_0001;

    if (manual_reset) begin
      case (rmode)
        latch_delayed_reset_mode: nxt_state.pend = state_ff.out;
        default: begin
          nxt_state.out = 1'b0;
          nxt_state.man_clr = state_ff.out;
          nxt_state.dly_cnt = 13'h0000;
        end
      endcase
    end

    if (meas_update || (apb_wr && paddr == SPT_CMD_OFF && wdata[CMD_UPDATE_BIT])) begin
      if (state_ff.first) begin
        nxt_state.first = 1'b0;
        if (rmode != auto_reset_mode && !at_off && !(state_ff.meas < state_ff.spt)) begin
          nxt_state.out = 1'b0;
        end
        nxt_state.pend = 1'b0;
      end
      // standby only lives until the first update when the option is off
      if (state_ff.first && !state_ff.ctrl[CTRL_STBY_BIT]) begin
        nxt_state.stby = 1'b0;
      end
      if (state_ff.stby && at_on) begin
        nxt_state.stby = 1'b0;
      end
      if (state_ff.man_clr && !at_on) begin
        nxt_state.man_clr = 1'b0;
      end
      want = state_ff.out;
      if (!state_ff.out) begin
        want = at_on && !state_ff.man_clr && !(state_ff.stby && !at_on) && !manual_reset;
      end else if (rmode == auto_reset_mode) begin
        want = !at_off;
      end else if (state_ff.pend && at_off) begin
        want = 1'b0;
      end
      dly_sel = want ? state_ff.on_dly : state_ff.off_dly;
      if (want == state_ff.out) begin
        nxt_state.dly_cnt = 13'h0000;
      end else if (dly_sel == 13'h0000 || state_ff.dly_cnt >= dly_sel) begin
        nxt_state.out = want;
        nxt_state.dly_cnt = 13'h0000;
        if (!want) begin
          nxt_state.pend = 1'b0;
        end
      end
      nxt_state.trig = at_on;
    end else if (tenth && state_ff.dly_cnt != DLY_MAX) begin
      nxt_state.dly_cnt = state_ff.dly_cnt + 13'h0001;
    end

    if (!state_ff.ctrl[CTRL_EN_BIT]) begin
      nxt_state.out = 1'b0;
      nxt_state.dly_cnt = 13'h0000;
    end
    if (nxt_state.stby) begin
      nxt_state.out = 1'b0;
    end

    if (state_ff.ctrl[CTRL_COLOR_BIT] && nxt_state.out != state_ff.out) begin
      nxt_state.color = ~state_ff.color;
    end
  end

  // ----------------------------------------------------------------
  // registers; standby flag set at power-up, kept until the first update
  // so that a standby enable written after power-up still takes hold
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= '0;
      state_ff.ctrl <= CTRL_RESET;
      state_ff.spt <= VALUE_RESET;
      state_ff.hyst <= HYST_RESET;
      state_ff.on_dly <= DLY_RESET;
      state_ff.off_dly <= DLY_RESET;
      state_ff.stby <= 1'b1;
      state_ff.first <= 1'b1;
    end else begin
      state_ff <= nxt_state;
    end
  end

endmodule

// file: dv/sptout_chk.sv
// checker for the setpoint output core, watching its ports only
// assumes one clock domain, pclk, with presetn as asynchronous reset
`timescale 1ns/1ps
module sptout_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic meas_update,
  input wire logic panel_reset,
  input wire logic user_reset,
  input wire logic setpoint_out,
  input wire logic backlight_alt
);
  import sptout_pkg::*;
  // ----------------------------------------------------------------
  // cause history: the output may answer an event up to three edges late
  // ----------------------------------------------------------------
  logic wr_now;
  logic upd_now;
  logic [2:0] evt_sr_ff;
  logic [2:0] upd_sr_ff;
  assign wr_now = psel & penable & pwrite;
  assign upd_now = meas_update | (wr_now & (paddr == SPT_CMD_OFF) & pwdata[CMD_UPDATE_BIT]);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_sr_ff <= 3'h0;
      upd_sr_ff <= 3'h0;
    end else begin
      evt_sr_ff <= {evt_sr_ff[1:0], upd_now | wr_now | panel_reset | user_reset};
      upd_sr_ff <= {upd_sr_ff[1:0], upd_now};
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_high: assert property (pready) else $error("pready low");
  a_no_slverr: assert property (!pslverr) else $error("pslverr high");
  a_rdata_hold: assert property ($changed(prdata) |-> $past(psel & !penable & !pwrite))
    else $error("prdata moved outside a read setup");
  a_unmapped_zero: assert property (psel & penable & !pwrite & (paddr > 8'h1C) |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_out_cause: assert property ($changed(setpoint_out) |-> |evt_sr_ff)
    else $error("output moved without update or reset");
  a_rise_update: assert property ($rose(setpoint_out) |-> |upd_sr_ff)
    else $error("output rose without update");
  a_colour_follow: assert property ($changed(backlight_alt) |->
    (setpoint_out != $past(setpoint_out)) || ($past(setpoint_out) != $past(setpoint_out, 2)))
    else $error("colour moved without output change");
  a_powerup_off: assert property ($rose(presetn) |-> !setpoint_out)
    else $error("output on at power-up");
  c_out_on: cover property ($rose(setpoint_out));
  c_out_off: cover property ($fell(setpoint_out));
  c_colour: cover property ($changed(backlight_alt));
endmodule
bind sptout_core sptout_chk u_sptout_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .meas_update, .panel_reset, .user_reset, .setpoint_out,
  .backlight_alt);

// file: dv/sptout_card.sv
// partner model: output card and the operator's reset buttons
// assumes the bench calls press() between measurement updates
`timescale 1ns/1ps
module sptout_card (
  input wire logic pclk,
  input wire logic setpoint_out,
  output logic panel_reset,
  output logic user_reset
);
  int edges_seen = 0;
  initial panel_reset = 1'b0;
  initial user_reset = 1'b0;
  // momentary press, one clock wide, launched just after a rising edge
  task automatic press(input bit use_user);
    @(posedge pclk);
    if (use_user) user_reset <= 1'b1;
    else panel_reset <= 1'b1;
    @(posedge pclk);
    panel_reset <= 1'b0;
    user_reset <= 1'b0;
  endtask
  // relay coil only counts switchings; which hysteresis suits it is the user's pick
  always @(setpoint_out) edges_seen++;
endmodule

// file: dv/sptout_core_tb.sv
// testbench for the setpoint output core, one task per scenario
// assumes zero-wait apb and the card model driving the reset buttons
`timescale 1ns/1ps
module sptout_core_tb;
  import sptout_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic meas_update = 1'b0;
  logic panel_dsp = 1'b1;
  logic user_dsp = 1'b1;
  logic disp_on = 1'b1;
  logic [31:0] prdata;
  logic pready, pslverr, panel_reset, user_reset, setpoint_out, backlight_alt;
  int err_total = 0;
  int compares = 0;
  always #25 pclk = ~pclk;
  sptout_core u_sptout_core (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .meas_update, .meas_value(32'h0), .panel_reset, .user_reset,
    .panel_rst_is_dsp(panel_dsp), .user_rst_is_dsp(user_dsp), .input_displayed(disp_on),
    .setpoint_out,
    .backlight_alt);
  sptout_card u_sptout_card (.pclk, .setpoint_out, .panel_reset, .user_reset);
  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic got);
    chk32(what, {31'h0, exp}, {31'h0, got});
  endtask
  task automatic chk_rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk32(what, exp, q);
  endtask
  task automatic upd(input logic [31:0] m, input bit by_pin);
    wr(SPT_MEAS_OFF, m);
    if (by_pin) begin
      @(posedge pclk);
      meas_update <= 1'b1;
      @(posedge pclk);
      meas_update <= 1'b0;
    end else wr(SPT_CMD_OFF, 32'h1 << CMD_UPDATE_BIT);
    repeat (3) @(posedge pclk);
  endtask
  // setpoint 100, hysteresis 10, enabled
  task automatic cfg(input logic [1:0] act, input logic [1:0] mode, input logic [11:0] opt);
    wr(SPT_CTRL_OFF, {20'h0, opt | (12'h1 << CTRL_EN_BIT) | {8'h0, mode, act}});
    wr(SPT_VALUE_OFF, 32'h64);
    wr(SPT_HYST_OFF, 32'hA);
  endtask
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    chk_rd("ctrl", SPT_CTRL_OFF, {20'h0, CTRL_RESET});
    chk_rd("hyst", SPT_HYST_OFF, {16'h0, HYST_RESET});
    chk_rd("unmapped", 8'h20, 32'h0);
    wr(SPT_VALUE_OFF, 32'h0001_86A0);
    chk_rd("sp max", SPT_VALUE_OFF, 32'h0001_869F);
    wr(SPT_VALUE_OFF, 32'hFFFF_B1E0);
    chk_rd("sp min", SPT_VALUE_OFF, 32'hFFFF_B1E1);
    wr(SPT_HYST_OFF, 32'h0);
    chk_rd("hy min", SPT_HYST_OFF, 32'h1);
    wr(SPT_HYST_OFF, 32'hEA60);
    chk_rd("hy max", SPT_HYST_OFF, 32'hEA5F);
  endtask
  // every action walks off, on, still on inside the band, off
  task automatic t_actions();
    logic [7:0] m [4][4] = '{'{8'h6D, 8'h6F, 8'h5B, 8'h59}, '{8'h5B, 8'h59, 8'h6D, 8'h6F},
      '{8'h63, 8'h65, 8'h5B, 8'h59}, '{8'h65, 8'h63, 8'h6D, 8'h6F}};
    logic [3:0] e = 4'h6;
    for (int a = 0; a < 4; a++) begin
      cfg(2'(a), 2'h0, 12'h0);
      for (int i = 0; i < 4; i++) begin
        upd({24'h0, m[a][i]}, i[0]);
        chk1("act out", e[i], setpoint_out);
      end
    end
  endtask
  // a tenth of a second is far beyond these waits, so a delayed output must not move
  task automatic t_delay();
    cfg(2'h0, 2'h0, 12'h0);
    wr(SPT_OFFDLY_OFF, 32'h1);
    upd(32'h78, 1'b1);
    upd(32'h50, 1'b1);
    chk1("off delayed", 1'b1, setpoint_out);
    do_reset();
    cfg(2'h0, 2'h0, 12'h0);
    wr(SPT_ONDLY_OFF, 32'h1);
    upd(32'h78, 1'b0);
    repeat (20) @(posedge pclk);
    chk1("on delayed", 1'b0, setpoint_out);
    do_reset();
  endtask
  task automatic t_auto();
    cfg(2'h0, 2'h0, 12'h0);
    upd(32'h78, 1'b1);
    u_sptout_card.press(1'b0);
    repeat (3) @(posedge pclk);
    chk1("auto manual", 1'b0, setpoint_out);
    upd(32'h78, 1'b0);
    chk1("auto held", 1'b0, setpoint_out);
    upd(32'h50, 1'b1);
    upd(32'h78, 1'b1);
    chk1("auto recross", 1'b1, setpoint_out);
    upd(32'h50, 1'b0);
    chk1("auto off", 1'b0, setpoint_out);
  endtask
  task automatic t_latch();
    cfg(2'h0, 2'h1, 12'h0);
    upd(32'h78, 1'b1);
    upd(32'h50, 1'b0);
    chk1("latched", 1'b1, setpoint_out);
    u_sptout_card.press(1'b1);
    repeat (3) @(posedge pclk);
    chk1("imm reset", 1'b0, setpoint_out);
    upd(32'h50, 1'b0);
    upd(32'h78, 1'b1);
    chk1("imm recross", 1'b1, setpoint_out);
    wr(SPT_CMD_OFF, 32'h1 << CMD_SERIAL_BIT);
    repeat (3) @(posedge pclk);
    chk1("serial reset", 1'b0, setpoint_out);
    cfg(2'h0, 2'h2, 12'h0);
    upd(32'h50, 1'b1);
    upd(32'h78, 1'b1);
    u_sptout_card.press(1'b0);
    repeat (3) @(posedge pclk);
    chk1("dly pending", 1'b1, setpoint_out);
    chk_rd("dly status", SPT_STATUS_OFF, 32'h13);
    upd(32'h50, 1'b0);
    chk1("dly applied", 1'b0, setpoint_out);
  endtask
  task automatic t_colour();
    logic b;
    cfg(2'h0, 2'h0, 12'h1 << CTRL_COLOR_BIT);
    b = backlight_alt;
    upd(32'h78, 1'b1);
    chk1("colour on", ~b, backlight_alt);
    upd(32'h50, 1'b0);
    chk1("colour off", b, backlight_alt);
  endtask
  task automatic t_power();
    cfg(2'h0, 2'h2, 12'h0);
    upd(32'h78, 1'b1);
    u_sptout_card.press(1'b1);
    do_reset();
    chk1("power off", 1'b0, setpoint_out);
    cfg(2'h0, 2'h2, 12'h1 << CTRL_STBY_BIT);
    chk_rd("power status", SPT_STATUS_OFF, 32'h4);
    upd(32'h50, 1'b1);
    chk1("standby held", 1'b0, setpoint_out);
    upd(32'h78, 1'b0);
    chk1("standby left", 1'b1, setpoint_out);
  endtask
  task automatic report_and_stop();
    if (err_total == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    do_reset();
    t_regs();
    t_actions();
    t_delay();
    t_auto();
    t_latch();
    t_colour();
    t_power();
    report_and_stop();
  end
  initial begin
    #(50 * 40000);
    err_total++;
    report_and_stop();
  end
endmodule
